// File: timing_clock_io_map.vh
// constants for the timing clock input and output block
`ifndef TIMING_CLOCK_IO_MAP_VH
`define TIMING_CLOCK_IO_MAP_VH

// phase accumulator width and tuning scale (synthesis scale 125 MHz)
`define ACC_W             32
`define SYNTH_SCALE_HZ    125000000
// tuning word for one 8 kHz step: 8000 * 2^32 / 125e6, rounded
`define STEP_WORD         32'h0004_31BE
`define FREQ_UNIT_HZ      8000
// largest programmable synthesizer frequency in 8 kHz units: 100 MHz
`define MAX_FREQ_UNITS    14'h30D4
// ethernet clock frequency codes
`define ETH_SEL_25M       2'h0
`define ETH_SEL_50M       2'h1
`define ETH_SEL_62M5      2'h2
`define ETH_SEL_125M      2'h3
// ethernet tuning words on the synthesis scale
`define ETH_WORD_25M      32'h3333_3333
`define ETH_WORD_50M      32'h6666_6666
`define ETH_WORD_62M5     32'h8000_0000
`define ETH_WORD_125M     32'hFFFF_FFFF
// reset values of the settings
`define ETH_SEL_RESET     2'h2
`define FREQ_UNITS_RESET  14'h0000
`define RATIO_RESET       8'h01
`define FP_PERIOD_RESET   16'h0001
`define FP_WIDTH_RESET    16'h0001
// synth clock 1 derivation modes
`define MODE_MULTIPLY     1'b0
`define MODE_DIVIDE       1'b1

`endif

// File: phase_nco.v
// numerically controlled oscillator used for synth clock 0, multiplied synth clock 1 and the ethernet clocks
`timescale 1ns/100ps
module phase_nco #(
    parameter ACC_W = 32
) (
    // clock and reset
    input  wire             ref_clk,
    input  wire             reset,
    // control
    input  wire [ACC_W-1:0] word,
    input  wire             phase_clear,
    // outputs
    output reg              clk_out,
    output reg              wrap
);

    reg  [ACC_W-1:0] acc_q;
    wire [ACC_W:0]   sum = {1'b0, acc_q} + {1'b0, word};

    always @(posedge ref_clk) begin
        if (reset || phase_clear) begin
            acc_q   <= {ACC_W{1'b0}};
            clk_out <= 1'b0;
            wrap    <= 1'b0;
        end else begin
            acc_q   <= sum[ACC_W-1:0];
            clk_out <= sum[ACC_W-1];
            wrap    <= sum[ACC_W];
        end
    end

endmodule // phase_nco

// File: timing_clock_io_control.v
// clock input routing, synthesized clocks, frame pulses and ethernet clocks
`timescale 1ns/100ps
`include "timing_clock_io_map.vh"

// Functional notes
// - master reference accepted, 8 kHz to 77.76 MHz
// - selectable reference pre-division for faster inputs
// - master reference routed to DPLL and timestamps
// - locked: frame pulses aligned to sync input
// - synth clock programmable in 8 kHz steps
// - synth clock 1 multiplies or divides clock 0
// - frame pulse style configurable, server alignment option
// - ethernet clocks: 25, 50, 62.5, 125 MHz
// - ethernet clocks start at 62.5 MHz
// - monitor output copies selected reference
// - monitor may glitch on reference change
module timing_clock_io_control #(
    parameter REFS   = 2,
    parameter SEL_W  = 1,
    parameter ACC_W  = `ACC_W
) (
    // clock and reset
    input  wire              ref_clk,
    input  wire              reset,
    // oscillator pins
    input  wire              oscillator_input,
    output wire              crystal_drive_output,
    // references and alignment
    input  wire [REFS-1:0]   ref_in,
    input  wire [SEL_W-1:0]  ref_sel,
    input  wire [7:0]        prediv_ratio,
    input  wire              sync_in,
    input  wire              dpll_locked,
    input  wire              two_way_en,
    input  wire              server_align,
    // settings
    input  wire              settings_load,
    input  wire [13:0]       synth_freq_units,
    input  wire              synth1_mode,
    input  wire [7:0]        synth1_ratio,
    input  wire [15:0]       fp_period,
    input  wire [15:0]       fp_width,
    input  wire [1:0]        fp_polarity,
    input  wire              fp_clock_style,
    input  wire [1:0]        eth0_freq_sel,
    input  wire [1:0]        eth1_freq_sel,
    // dpll side
    output reg               dpll_ref,
    output reg               dpll_ref_edge,
    output reg  [31:0]       timestamp_q,
    // clock outputs and ethernet code readback
    output reg               selected_reference_monitor,
    output reg  [1:0]        synth_output_clock,
    output reg  [1:0]        synth_frame_pulse,
    output wire [1:0]        ethernet_phy_clock,
    output wire [3:0]        eth_code_q
);

    // settings registers
    reg  [13:0] units_q;
    reg         mode_q;
    reg  [7:0]  ratio_q;
    reg  [15:0] period_q;
    reg  [15:0] width_q;
    reg  [1:0]  pol_q;
    reg         style_q;
    reg  [1:0]  eth0_q;
    reg  [1:0]  eth1_q;

    // reference path
    reg         ref_q;
    reg         ref_prev_q;
    reg  [7:0]  pre_cnt_q;
    reg  [31:0] local_time_q;
    reg         sync_prev_q;
    reg         server_prev_q;

    // frame and synth 1 state
    reg  [15:0] fp_cnt_q;
    reg  [7:0]  div_cnt_q;

    wire        clk0;
    wire        wrap0;
    wire        clk1_mul;
    wire        eth0_clk;
    wire        eth1_clk;
    wire        align;
    wire [45:0] word0_full;
    wire [39:0] word1_full;
    wire [7:0]  pre_n;
    wire [7:0]  div_n;
    wire [15:0] fp_n;
    wire [15:0] fp_on;
    wire        fp_active;
    wire        ref_rise;
    reg  [31:0] eth0_word;
    reg  [31:0] eth1_word;

    // crystal loop inverter; the drive pin always carries the inverted oscillator input
    assign crystal_drive_output = ~oscillator_input;

    // host settings are captured on a load strobe and set to their defaults on reset
    always @(posedge ref_clk) begin
        if (reset) begin
            units_q  <= `FREQ_UNITS_RESET;
            mode_q   <= `MODE_MULTIPLY;
            ratio_q  <= `RATIO_RESET;
            period_q <= `FP_PERIOD_RESET;
            width_q  <= `FP_WIDTH_RESET;
            pol_q    <= 2'h0;
            style_q  <= 1'b0;
            eth0_q   <= `ETH_SEL_RESET;
            eth1_q   <= `ETH_SEL_RESET;
        end else if (settings_load) begin
            units_q  <= (synth_freq_units > `MAX_FREQ_UNITS) ?
                        `MAX_FREQ_UNITS : synth_freq_units;
            mode_q   <= synth1_mode;
            ratio_q  <= synth1_ratio;
            period_q <= fp_period;
            width_q  <= fp_width;
            pol_q    <= fp_polarity;
            style_q  <= fp_clock_style;
            eth0_q   <= eth0_freq_sel;
            eth1_q   <= eth1_freq_sel;
        end
    end

    assign eth_code_q = {eth1_q, eth0_q};

    // reference selection; monitor is a registered mux and may glitch on a switch
    always @(posedge ref_clk) begin
        if (reset) begin
            ref_q                      <= 1'b0;
            ref_prev_q                 <= 1'b0;
            selected_reference_monitor <= 1'b0;
        end else begin
            ref_q                      <= ref_in[ref_sel];
            ref_prev_q                 <= ref_q;
            selected_reference_monitor <= ref_in[ref_sel];
        end
    end

    assign ref_rise = ref_q & ~ref_prev_q;
    assign pre_n    = (prediv_ratio == 8'h00) ? 8'h01 : prediv_ratio;

    // pre-divider feeding the dpll and the timestamp capture
    always @(posedge ref_clk) begin
        if (reset) begin
            pre_cnt_q     <= 8'h00;
            dpll_ref      <= 1'b0;
            dpll_ref_edge <= 1'b0;
            local_time_q  <= 32'h0000_0000;
            timestamp_q   <= 32'h0000_0000;
        end else begin
            local_time_q  <= local_time_q + 32'h0000_0001;
            dpll_ref_edge <= 1'b0;
            if (ref_rise) begin
                if (pre_cnt_q >= pre_n - 8'h01) begin
                    pre_cnt_q     <= 8'h00;
                    dpll_ref_edge <= 1'b1;
                    timestamp_q   <= local_time_q;
                end else begin
                    pre_cnt_q <= pre_cnt_q + 8'h01;
                end
            end
            if (pre_n == 8'h01) begin
                dpll_ref <= ref_q;
            end else begin
                dpll_ref <= (pre_cnt_q < {1'b0, pre_n[7:1]});
            end
        end
    end

    // alignment events from the sync input or the server signal
    always @(posedge ref_clk) begin
        if (reset) begin
            sync_prev_q   <= 1'b0;
            server_prev_q <= 1'b0;
        end else begin
            sync_prev_q   <= sync_in;
            server_prev_q <= server_align;
        end
    end

    // a sync pulse must span a sampling edge to be seen
    assign align = (dpll_locked & sync_in & ~sync_prev_q & ~two_way_en) |
                   (two_way_en & server_align & ~server_prev_q);

    // synth clock 0 tuning word from the 8 kHz step count
    assign word0_full = {32'h0000_0000, units_q} * {14'h0000, `STEP_WORD};
    assign word1_full = {8'h00, word0_full[31:0]} * {32'h0000_0000, ratio_q};

    phase_nco #(.ACC_W(ACC_W)) nco_synth0 (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .word        (word0_full[ACC_W-1:0]),
        .phase_clear (align),
        .clk_out     (clk0),
        .wrap        (wrap0)
    );

    phase_nco #(.ACC_W(ACC_W)) nco_synth1 (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .word        (word1_full[ACC_W-1:0]),
        .phase_clear (align),
        .clk_out     (clk1_mul),
        .wrap        ()
    );

    assign div_n = (ratio_q == 8'h00) ? 8'h01 : ratio_q;
    assign fp_n  = (period_q == 16'h0000) ? 16'h0001 : period_q;
    assign fp_on = style_q ? {1'b0, fp_n[15:1]} : width_q;
    assign fp_active = (fp_cnt_q < fp_on);

    // frame counter and divided synth clock 1, both restarted on alignment
    always @(posedge ref_clk) begin
        if (reset) begin
            fp_cnt_q  <= 16'h0000;
            div_cnt_q <= 8'h00;
        end else if (align) begin
            fp_cnt_q  <= 16'h0000;
            div_cnt_q <= 8'h00;
        end else if (wrap0) begin
            fp_cnt_q  <= (fp_cnt_q >= fp_n - 16'h0001) ? 16'h0000 : fp_cnt_q + 16'h0001;
            div_cnt_q <= (div_cnt_q >= div_n - 8'h01) ? 8'h00 : div_cnt_q + 8'h01;
        end
    end

    // registered synth outputs
    always @(posedge ref_clk) begin
        if (reset) begin
            synth_output_clock <= 2'h0;
            synth_frame_pulse  <= 2'h0;
        end else begin
            synth_output_clock[0] <= clk0;
            if (mode_q == `MODE_MULTIPLY) begin
                synth_output_clock[1] <= clk1_mul;
            end else if (div_n == 8'h01) begin
                synth_output_clock[1] <= clk0;
            end else begin
                synth_output_clock[1] <= (div_cnt_q < {1'b0, div_n[7:1]});
            end
            synth_frame_pulse <= {2{fp_active}} ^ pol_q;
        end
    end

    // ethernet clock tuning words
    always @* begin
        case (eth0_q)
            `ETH_SEL_25M: eth0_word = `ETH_WORD_25M;
            `ETH_SEL_50M: eth0_word = `ETH_WORD_50M;
            `ETH_SEL_62M5: eth0_word = `ETH_WORD_62M5;
            default: eth0_word = `ETH_WORD_125M;
        endcase
        case (eth1_q)
            `ETH_SEL_25M: eth1_word = `ETH_WORD_25M;
            `ETH_SEL_50M: eth1_word = `ETH_WORD_50M;
            `ETH_SEL_62M5: eth1_word = `ETH_WORD_62M5;
            default: eth1_word = `ETH_WORD_125M;
        endcase
    end

    phase_nco #(.ACC_W(32)) nco_eth0 (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .word        (eth0_word),
        .phase_clear (1'b0),
        .clk_out     (eth0_clk),
        .wrap        ()
    );

    phase_nco #(.ACC_W(32)) nco_eth1 (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .word        (eth1_word),
        .phase_clear (1'b0),
        .clk_out     (eth1_clk),
        .wrap        ()
    );

    assign ethernet_phy_clock = {eth1_clk, eth0_clk};

endmodule // timing_clock_io_control

// File: timing_clock_io_control_sva.sv
// checker bound to the timing clock io block
`timescale 1ns/100ps
module timing_clock_io_control_chk #(
    parameter REFS  = 2,
    parameter SEL_W = 1
) (
    // clock and reset
    input wire             ref_clk,
    input wire             reset,
    // inputs
    input wire             oscillator_input,
    input wire [REFS-1:0]  ref_in,
    input wire [SEL_W-1:0] ref_sel,
    input wire             sync_in,
    input wire             dpll_locked,
    input wire             two_way_en,
    input wire             server_align,
    input wire             settings_load,
    input wire [1:0]       fp_polarity,
    input wire [1:0]       eth0_freq_sel,
    input wire [1:0]       eth1_freq_sel,
    // outputs
    input wire             crystal_drive_output,
    input wire             dpll_ref_edge,
    input wire [31:0]      timestamp_q,
    input wire             selected_reference_monitor,
    input wire [1:0]       synth_frame_pulse,
    input wire [3:0]       eth_code_q
);
    // polarity last loaded, to know the active level of the frame pulses
    reg [1:0] pol_q;
    always @(posedge ref_clk) begin
        pol_q <= reset ? 2'h0 : (settings_load ? fp_polarity : pol_q);
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence ref_idle; !ref_in[ref_sel] [*5]; endsequence
    sequence sync_rise; $rose(sync_in) && dpll_locked && !two_way_en; endsequence
    sequence server_rise; $rose(server_align) && dpll_locked && two_way_en; endsequence
    AST_XTAL_INV: assert property (crystal_drive_output == !oscillator_input)
        else $error("crystal drive is not the inverse");
    AST_MON_COPY: assert property (!$past(reset) |->
        selected_reference_monitor == $past(ref_in[ref_sel]))
        else $error("monitor differs from selected reference");
    AST_ETH_RESET: assert property ($past(reset) |-> eth_code_q == 4'hA)
        else $error("ethernet codes not at start value");
    AST_ETH_LOAD: assert property (settings_load |=>
        eth_code_q == $past({eth1_freq_sel, eth0_freq_sel}))
        else $error("ethernet codes not applied");
    AST_REF_IDLE: assert property (ref_idle |-> !dpll_ref_edge)
        else $error("reference edge without a reference rise");
    AST_STAMP: assert property ($changed(timestamp_q) |-> dpll_ref_edge)
        else $error("timestamp moved without a reference edge");
    AST_SYNC: assert property (sync_rise |-> ##[1:3] synth_frame_pulse == ~pol_q)
        else $error("frame pulse not aligned to sync");
    AST_SERVER: assert property (server_rise |-> ##[1:3] synth_frame_pulse == ~pol_q)
        else $error("frame pulse not aligned to server");
endmodule // timing_clock_io_control_chk

bind timing_clock_io_control timing_clock_io_control_chk #(.REFS(REFS), .SEL_W(SEL_W)) chk_i (
    .ref_clk(ref_clk), .reset(reset), .oscillator_input(oscillator_input),
    .ref_in(ref_in), .ref_sel(ref_sel), .sync_in(sync_in), .dpll_locked(dpll_locked),
    .two_way_en(two_way_en), .server_align(server_align), .settings_load(settings_load),
    .fp_polarity(fp_polarity), .eth0_freq_sel(eth0_freq_sel), .eth1_freq_sel(eth1_freq_sel),
    .crystal_drive_output(crystal_drive_output), .dpll_ref_edge(dpll_ref_edge),
    .timestamp_q(timestamp_q), .selected_reference_monitor(selected_reference_monitor),
    .synth_frame_pulse(synth_frame_pulse), .eth_code_q(eth_code_q));

// File: clock_sink.sv
// downstream clock receiver model that counts rising edges
`timescale 1ns/100ps
module clock_sink (
    // sampling clock and count clear
    input  wire        ref_clk,
    input  wire        clear,
    // received clock
    input  wire        clk_in,
    // rising edges seen since clear
    output reg  [15:0] edges
);
    reg last_q;
    always @(posedge ref_clk) begin
        last_q <= clk_in;
        if (clear) edges <= 16'h0000;
        else if (clk_in && !last_q) edges <= edges + 16'h0001;
    end
endmodule // clock_sink

// File: tb_timing_clock_io_control.sv
// self-checking bench for the timing clock io block
`timescale 1ns/100ps
`include "timing_clock_io_map.vh"
module tb_timing_clock_io_control;
    // design inputs
    logic        ref_clk, reset, oscillator_input, sync_in, dpll_locked, two_way_en;
    logic        server_align, settings_load, synth1_mode, fp_clock_style, clear;
    logic [1:0]  ref_in, fp_polarity, eth0_freq_sel, eth1_freq_sel;
    logic [0:0]  ref_sel;
    logic [7:0]  prediv_ratio, synth1_ratio;
    logic [13:0] synth_freq_units;
    logic [15:0] fp_period, fp_width;
    // design outputs
    wire         crystal_drive_output, dpll_ref, dpll_ref_edge, selected_reference_monitor;
    wire  [31:0] timestamp_q;
    wire  [1:0]  synth_output_clock, synth_frame_pulse, ethernet_phy_clock;
    wire  [3:0]  eth_code_q;
    wire  [63:0] edge_cnt;
    int          bad_count, total_checks, cycles;

    timing_clock_io_control timing_clock_io_control_i (
        .ref_clk(ref_clk), .reset(reset), .oscillator_input(oscillator_input),
        .crystal_drive_output(crystal_drive_output), .ref_in(ref_in), .ref_sel(ref_sel),
        .prediv_ratio(prediv_ratio), .sync_in(sync_in), .dpll_locked(dpll_locked),
        .two_way_en(two_way_en), .server_align(server_align), .settings_load(settings_load),
        .synth_freq_units(synth_freq_units), .synth1_mode(synth1_mode),
        .synth1_ratio(synth1_ratio), .fp_period(fp_period), .fp_width(fp_width),
        .fp_polarity(fp_polarity), .fp_clock_style(fp_clock_style),
        .eth0_freq_sel(eth0_freq_sel), .eth1_freq_sel(eth1_freq_sel), .dpll_ref(dpll_ref),
        .dpll_ref_edge(dpll_ref_edge), .timestamp_q(timestamp_q),
        .selected_reference_monitor(selected_reference_monitor),
        .synth_output_clock(synth_output_clock), .synth_frame_pulse(synth_frame_pulse),
        .ethernet_phy_clock(ethernet_phy_clock), .eth_code_q(eth_code_q));
    clock_sink clock_sink_i [3:0] (.ref_clk(ref_clk), .clear(clear),
        .clk_in({ethernet_phy_clock, synth_output_clock}), .edges(edge_cnt));

    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            results;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input int tol);
        total_checks++;
        if ($isunknown(seen) || (tol == 0 ? seen !== exp : (seen > exp + tol || seen + tol < exp)))
        begin
            bad_count++;
            $display("Error at %0t: saw %0d expected %0d", $time, seen, exp);
        end
    endtask
    task tick(input int n); repeat (n) @(negedge ref_clk); endtask
    task load; settings_load = 1; tick(1); settings_load = 0; endtask
    task measure; clear = 1; tick(1); clear = 0; tick(1000); endtask
    // rising edges per 1000 cycles of a registered accumulator msb, folded by aliasing
    function automatic int rises(input logic [31:0] w);
        logic [31:0] a;
        a = w[31] ? -w : w;
        return int'((64'd1000 * a) >> 32);
    endfunction
    task t_reset;
        check(eth_code_q, 4'hA, 0);
        oscillator_input = 1;
        tick(1);
        check(crystal_drive_output, 0, 0);
        measure;
        check(edge_cnt[47:32], rises(`ETH_WORD_62M5), 2);
        check(edge_cnt[63:48], rises(`ETH_WORD_62M5), 2);
    endtask
    task automatic t_eth;
        logic [31:0] w [4] = '{`ETH_WORD_25M, `ETH_WORD_50M, `ETH_WORD_62M5, `ETH_WORD_125M};
        for (int c = 0; c < 4; c++) begin
            eth0_freq_sel = 2'(c);
            eth1_freq_sel = 2'(3 - c);
            load;
            check(eth_code_q, {eth1_freq_sel, eth0_freq_sel}, 0);
            tick(3);
            measure;
            check(edge_cnt[47:32], rises(w[c]), 2);
            check(edge_cnt[63:48], rises(w[3 - c]), 2);
        end
    endtask
    task automatic t_synth;
        logic [13:0] u [4] = '{14'h30D4, 14'h3FFF, 14'h03E8, 14'h03E8};
        logic [7:0] r [4] = '{8'h01, 8'h01, 8'h03, 8'h04};
        logic [31:0] w0;
        for (int i = 0; i < 4; i++) begin
            synth_freq_units = u[i];
            synth1_mode = (i == 3);
            synth1_ratio = r[i];
            load;
            tick(3);
            measure;
            w0 = (u[i] > `MAX_FREQ_UNITS ? `MAX_FREQ_UNITS : u[i]) * `STEP_WORD;
            check(edge_cnt[15:0], rises(w0), 2);
            check(edge_cnt[31:16], synth1_mode ? rises(w0) / r[i] : rises(w0 * r[i]), 2);
        end
    endtask
    task automatic t_ref(input logic [0:0] sel, input logic [7:0] n, input int exp);
        int got = 0;
        int stamp = 0;
        logic lvl = 0;
        ref_sel = sel;
        prediv_ratio = n;
        for (int i = 0; i < 36; i++) begin
            ref_in[sel] = i[1] & (i < 32);
            ref_in[~sel] = ~i[1] & (i < 32);
            tick(1);
            check(selected_reference_monitor, i[1] & (i < 32), 0);
            if (n < 2) check(dpll_ref, lvl, 0);
            lvl = ref_in[sel];
            if (dpll_ref_edge) begin
                if (got > 0) check(timestamp_q - stamp, (n < 2) ? 4 : 8, 0);
                stamp = timestamp_q;
                got++;
            end
        end
        check(got, exp, 0);
    endtask
    task automatic t_align(input logic way, input logic [1:0] pol);
        logic [1:0] act;
        act = ~pol;
        fp_polarity = pol;
        fp_clock_style = way;
        load;
        two_way_en = way;
        dpll_locked = 1;
        tick(2);
        repeat (2) begin
            if (way) server_align = 1;
            else sync_in = 1;
            tick(2);
            check(synth_frame_pulse, act, 0);
            {sync_in, server_align} = 2'h0;
            tick(100);
            check(synth_frame_pulse, way ? act : pol, 0);
            tick(800);
            check(synth_frame_pulse, pol, 0);
        end
        // a sync rise while unlocked or in two-way mode must not realign
        dpll_locked = way;
        sync_in = 1;
        tick(2);
        check(synth_frame_pulse, pol, 0);
        {sync_in, dpll_locked, two_way_en} = 3'h0;
        tick(2);
    endtask
    task results;
        if (bad_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        {ref_clk, reset, oscillator_input, sync_in, dpll_locked, two_way_en} = 6'h10;
        {server_align, settings_load, synth1_mode, fp_clock_style, clear} = 5'h00;
        {ref_in, ref_sel, fp_polarity, eth0_freq_sel, eth1_freq_sel} = 9'h000;
        {prediv_ratio, synth1_ratio, synth_freq_units} = {8'h01, 8'h01, 14'h0000};
        {fp_period, fp_width} = {16'h0064, 16'h0003};
        {bad_count, total_checks, cycles} = 0;
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        reset = 0;
        tick(1);
        t_reset;
        t_eth;
        t_synth;
        t_ref(1'b0, 8'h01, 8);
        t_ref(1'b1, 8'h00, 8);
        t_ref(1'b0, 8'h02, 4);
        t_align(1'b0, 2'h0);
        t_align(1'b1, 2'h3);
        results;
    end
endmodule // tb_timing_clock_io_control
